// file: verilog/dra_alu.sv
`timescale 1ns/100ps
`default_nettype none
`include "dra_cfg.svh"
module dra_alu #(
	parameter int W = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         reset,
	input  wire logic [W-1:0] a_bus,
	input  wire logic [W-1:0] b_bus,
	input  wire logic         first_source_load_field,
	input  wire logic         second_source_load_field,
	input  wire logic [2:0]   first_operand_gate_field,
	input  wire logic [1:0]   second_operand_gate_field,
	input  wire logic [1:0]   arith_mode_field,
	input  wire logic [2:0]   carry_function_field,
	input  wire logic         alu_strobe,
	input  wire logic         insert_carry,
	input  wire logic         carry_branch_mnemonic,
	input  wire logic         bit_one_carry_branch,
	input  wire logic         check_stop_sw,
	input  wire logic         hard_stop_sw,
	input  wire logic         mc7_clear,
	input  wire logic         addr_latch_set_req,
	input  wire logic [10:0]  rail_fault_inject,
	output logic      [W-1:0] z_bus_true,
	output logic      [W-1:0] z_bus_comp,
	output logic              carry_status_latch,
	output logic              carry_out_zero,
	output logic              carry_out_one,
	output logic              recomplement_needed,
	output logic              next_addr_bit6,
	output logic              next_addr_bit7,
	output logic              arith_unit_check,
	output logic              addr_latch_set,
	output logic              machine_check_7,
	output logic              any_machine_check,
	output logic              hard_stop,
	output logic              clock_start
);
	dra_pkg::dra_state_s st_reg;
	dra_pkg::dra_state_s st_next;

	logic [W-1:0] a_gated;
	logic [W-1:0] b_gated;
	logic [W-1:0] b_adder;
	logic [W-1:0] sum_add;
	logic [W-1:0] adder_out;
	logic [W-1:0] z_corr;
	logic [W:0]   carry;
	logic         cin_latch;
	logic         cin;
	logic         is_dec;
	logic         is_logic;
	logic         cout0;
	logic         cout1;
	logic         cout4;
	logic         check_now;
	logic         check_block;

	dra_gate #(
		.W    (W),
		.SWAP (1'b1)
	) u_gate_a (
		.data  (st_reg.a_src),
		.sel   (first_operand_gate_field),
		.gated (a_gated)
	); // RULE3

	dra_gate #(
		.W    (W),
		.SWAP (1'b0)
	) u_gate_b (
		.data  (st_reg.b_src),
		.sel   ({1'b0, second_operand_gate_field}),
		.gated (b_gated)
	); // RULE4

	assign is_dec = (arith_mode_field == `DRA_MODE_DEC_TRUE) || (arith_mode_field == `DRA_MODE_DEC_COMP);

	always_comb begin
		unique case (arith_mode_field)
			`DRA_MODE_BIN_TRUE: b_adder = b_gated; // RULE5
			`DRA_MODE_BIN_COMP: b_adder = ~b_gated; // RULE5
			`DRA_MODE_DEC_TRUE: b_adder = {4'(b_gated[7:4] + `DRA_DEC_BIAS),
				4'(b_gated[3:0] + `DRA_DEC_BIAS)}; // RULE6
			`DRA_MODE_DEC_COMP: b_adder = ~b_gated; // RULE5
		endcase
	end

	// Carry-in latch: insert line or status latch, only gated through by some codes
	assign cin_latch = insert_carry || st_reg.status; // RULE12
	always_comb begin
		unique case (carry_function_field)
			`DRA_CC_FORCE, `DRA_CC_FORCE_SET: cin = 1'b1; // RULE13
			`DRA_CC_SET, `DRA_CC_COND_SET:    cin = cin_latch; // RULE12
			default:                          cin = 1'b0;
		endcase
	end

	// Bit W-1 is position zero; ripple runs from position seven upward
	assign carry[0] = cin;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_add
			assign sum_add[i]  = a_gated[i] ^ b_adder[i] ^ carry[i];
			assign carry[i+1]  = (a_gated[i] & b_adder[i]) | (carry[i] & (a_gated[i] ^ b_adder[i])); // RULE11
		end
	endgenerate

	assign is_logic = (carry_function_field == `DRA_CC_OR) || (carry_function_field == `DRA_CC_AND) ||
		(carry_function_field == `DRA_CC_XOR);
	always_comb begin
		unique case (carry_function_field)
			`DRA_CC_OR:  adder_out = a_gated | b_adder; // RULE7
			`DRA_CC_AND: adder_out = a_gated & b_adder; // RULE7
			`DRA_CC_XOR: adder_out = a_gated ^ b_adder; // RULE7
			default:     adder_out = sum_add; // RULE7
		endcase
	end
	// Logic functions produce no carries, so in decimal mode both of their nibbles get corrected
	assign cout0 = carry[W] & !is_logic;
	assign cout1 = carry[W-1] & !is_logic;
	assign cout4 = carry[4] & !is_logic;

	dra_corr #(
		.NIBS (W / 4)
	) u_corr (
		.sum       (adder_out),
		.nib_carry ({cout0, cout4}),
		.decimal   (is_dec),
		.corrected (z_corr)
	); // RULE8 RULE10

	// Comparing stored rails; a stuck rail shows up as soon as it is captured, in the cycle after the strobe
	assign check_now = (|(~(st_reg.z_true ^ st_reg.z_comp))) ||
		(|(~(st_reg.chk_true ^ st_reg.chk_comp))); // RULE18
	assign check_block = check_now && check_stop_sw;

	always_comb begin
		st_next = st_reg;
		if (first_source_load_field) begin
			st_next.a_src = a_bus; // RULE1
		end
		if (second_source_load_field) begin
			st_next.b_src = b_bus; // RULE1
		end
		if (alu_strobe) begin
			st_next.z_true   = z_corr; // RULE2
			st_next.z_comp   = ~z_corr ^ rail_fault_inject[7:0]; // RULE2
			st_next.chk_true = {adder_out[W-1], adder_out[3], cout0};
			st_next.chk_comp = ~{adder_out[W-1], adder_out[3], cout0} ^ rail_fault_inject[10:8]; // RULE2
			st_next.carry0   = cout0;
			st_next.carry1   = cout1;
			st_next.recomp   = (arith_mode_field == `DRA_MODE_DEC_COMP) && !cout0; // RULE17
			unique case (carry_function_field)
				`DRA_CC_SET, `DRA_CC_FORCE_SET: st_next.status = cout0; // RULE13
				`DRA_CC_COND_SET: begin
					if (cin) begin
						st_next.status = cout0; // RULE14
					end
				end
				default: st_next.status = st_reg.status;
			endcase
		end
		st_next.br6 = carry_branch_mnemonic && st_reg.carry0; // RULE15
		st_next.br7 = bit_one_carry_branch && st_reg.carry1; // RULE16
		// Set beats clear so a check in the clearing cycle is not lost
		if (check_now) begin
			st_next.mc7 = 1'b1; // RULE20
		end else if (mc7_clear) begin
			st_next.mc7 = 1'b0;
		end
		if (check_now && hard_stop_sw) begin
			st_next.stop = 1'b1; // RULE21
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_reg <= '{z_comp: 8'hff, chk_comp: 3'h7, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign z_bus_true          = st_reg.z_true;
	assign z_bus_comp          = st_reg.z_comp;
	assign carry_status_latch  = st_reg.status;
	assign carry_out_zero      = st_reg.carry0;
	assign carry_out_one       = st_reg.carry1;
	assign recomplement_needed = st_reg.recomp;
	assign next_addr_bit6      = st_reg.br6;
	assign next_addr_bit7      = st_reg.br7;
	assign arith_unit_check    = check_now;
	assign addr_latch_set      = addr_latch_set_req && !check_block; // RULE19
	assign machine_check_7     = st_reg.mc7;
	assign any_machine_check   = check_now; // RULE21
	assign hard_stop           = st_reg.stop;
	// Hard stop also holds the clock off after the check itself has gone
	assign clock_start         = !check_block && !st_reg.stop; // RULE22

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	a_load_a: assert property (first_source_load_field |=> st_reg.a_src == $past(a_bus)) // RULE1
		else $error("first source register missed its load");
	rail_pair_a: assert property ($past(alu_strobe) && $past(rail_fault_inject) == 11'h0 // RULE2
		|-> (z_bus_true ^ z_bus_comp) == 8'hff)
		else $error("result rails not complementary");
	force_cin_a: assert property (carry_function_field == `DRA_CC_FORCE |-> cin) // RULE13
		else $error("forced carry-in missing");
	status_set_a: assert property (alu_strobe && carry_function_field == `DRA_CC_SET // RULE13
		|=> carry_status_latch == $past(cout0))
		else $error("status latch did not follow carry-out");
	cond_set_a: assert property (alu_strobe && carry_function_field == `DRA_CC_COND_SET && !cin // RULE14
		|=> $stable(carry_status_latch))
		else $error("status latch changed without carry-in");
	bin_pass_a: assert property (alu_strobe && !is_dec |=> z_bus_true == $past(adder_out)) // RULE8
		else $error("binary result altered by corrector");
	dec_fix_a: assert property (alu_strobe && is_dec && !cout4 // RULE9
		|=> z_bus_true[3:0] == 4'($past(adder_out[3:0]) - `DRA_DEC_BIAS))
		else $error("low nibble not corrected by six");
	hi_fix_a: assert property (alu_strobe && is_dec && !cout0 // RULE9
		|=> z_bus_true[7:4] == 4'($past(adder_out[7:4]) - `DRA_DEC_BIAS))
		else $error("high nibble not corrected by six");
	recomp_flag_a: assert property (alu_strobe && arith_mode_field == `DRA_MODE_DEC_COMP // RULE17
		|=> recomplement_needed == !$past(cout0))
		else $error("recomplement flag wrong");
	latch_pass_a: assert property (!arith_unit_check |-> addr_latch_set == addr_latch_set_req) // RULE19
		else $error("address latch request not passed");
	branch_six_a: assert property (alu_strobe ##1 carry_branch_mnemonic // RULE15
		|=> next_addr_bit6 == $past(carry_out_zero))
		else $error("branch bit 6 wrong");
	branch_seven_a: assert property (bit_one_carry_branch && carry_out_one |=> next_addr_bit7) // RULE16
		else $error("branch bit 7 not set");
	mc7_set_a: assert property (arith_unit_check |=> machine_check_7) // RULE20
		else $error("machine check 7 not set");
	clk_drop_a: assert property (arith_unit_check && check_stop_sw |-> !clock_start && !addr_latch_set) // RULE22
		else $error("clock start or address latch not blocked");
	stop_hold_a: assert property (arith_unit_check && hard_stop_sw |=> hard_stop [*3]) // RULE21
		else $error("hard stop not held");
endmodule
`default_nettype wire

// file: verilog/dra_cfg.svh
`ifndef DRA_CFG_SVH
`define DRA_CFG_SVH
// How it works
// RULE1 - Each source operand register loads from its own bus under its own load field.
// RULE2 - Every internal and result bit travels as a true and an inverted line; here only the result byte and the three check bits do.
// RULE3 - First gate passes, blocks, keeps high nibble, keeps low nibble or swaps nibbles.
// RULE4 - Second gate passes, blocks, keeps high or low nibble; it never swaps.
// RULE5 - Mode field picks binary or decimal, true or complement; complement inverts operand two.
// RULE6 - Decimal true addition adds six to each nibble of operand two first.
// RULE7 - Carry function field makes the adder add, OR, AND or exclusive-OR.
// RULE8 - Every result reaches the result bus through the corrector; binary passes unchanged.
// RULE9 - Decimal results: nibbles without top carry lose six, nibbles with carry stay.
// RULE10 - Nibble carries come from positions zero and four; correction carries are dropped.
// RULE11 - Carries ripple to the next more significant position in both modes.
// RULE12 - Carry into the lowest position comes from a latch set by insert or status latch.
// RULE13 - Code 001 forces carry-in; 100 sets status on carry-out; 101 does both.
// RULE14 - Code 110 lets carry-out set status only when a carry-in is present.
// RULE15 - Carry branch sets next-address bit 6 when the last arithmetic carried out.
// RULE16 - Bit-one carry branch sets next-address bit 7 on last carry from position one.
// RULE17 - In decimal complement addition a top carry means true form, else recomplement.
// RULE18 - Result pairs and sum-zero, sum-four, carry-zero pairs equal raise the unit check.
// RULE19 - The check blocks address-indicating latch setting while check-stop is on.
// RULE20 - The check sets machine-check latch 7 for the microprogram to test.
// RULE21 - The check raises general machine check and, per stop switch, a hard stop.
// RULE22 - With check-stop on, the check drops the processor clock-start line.
// RULE23 - Subtracting six is done as adding ten modulo sixteen inside each nibble.
`define DRA_GATE_PASS  3'h0
`define DRA_GATE_BLOCK 3'h1
`define DRA_GATE_HIGH  3'h2
`define DRA_GATE_LOW   3'h3
`define DRA_GATE_SWAP  3'h4
`define DRA_MODE_BIN_TRUE 2'h0
`define DRA_MODE_BIN_COMP 2'h1
`define DRA_MODE_DEC_TRUE 2'h2
`define DRA_MODE_DEC_COMP 2'h3
`define DRA_CC_NONE      3'h0
`define DRA_CC_FORCE     3'h1
`define DRA_CC_OR        3'h2
`define DRA_CC_AND       3'h3
`define DRA_CC_SET       3'h4
`define DRA_CC_FORCE_SET 3'h5
`define DRA_CC_COND_SET  3'h6
`define DRA_CC_XOR       3'h7
`define DRA_DEC_BIAS 4'h6
`define DRA_DEC_TEN  4'ha
`define DRA_NIB_W    4
`endif

// file: verilog/dra_pkg.sv
`default_nettype none
`include "dra_cfg.svh"
package dra_pkg;
	typedef struct packed {
		logic [7:0] a_src;
		logic [7:0] b_src;
		logic [7:0] z_true;
		logic [7:0] z_comp;
		logic [2:0] chk_true;
		logic [2:0] chk_comp;
		logic       carry0;
		logic       carry1;
		logic       status;
		logic       recomp;
		logic       br6;
		logic       br7;
		logic       mc7;
		logic       stop;
	} dra_state_s;
endpackage
`default_nettype wire

// file: verilog/dra_gate.sv
`timescale 1ns/100ps
`default_nettype none
`include "dra_cfg.svh"
module dra_gate #(
	parameter int W    = 8,
	parameter bit SWAP = 1'b1
) (
	input  wire logic [W-1:0] data,
	input  wire logic [2:0]   sel,
	output logic      [W-1:0] gated
);
	localparam int H = W / 2;
	always_comb begin
		unique case (sel)
			`DRA_GATE_PASS:  gated = data;
			`DRA_GATE_BLOCK: gated = '0;
			`DRA_GATE_HIGH:  gated = {data[W-1:H], {H{1'b0}}};
			`DRA_GATE_LOW:   gated = {{(W-H){1'b0}}, data[H-1:0]};
			// Swap exists only on the first operand side
			`DRA_GATE_SWAP:  gated = SWAP ? {data[H-1:0], data[W-1:H]} : '0;
			default:         gated = '0;
		endcase
	end
endmodule
`default_nettype wire

// file: verilog/dra_corr.sv
`timescale 1ns/100ps
`default_nettype none
`include "dra_cfg.svh"
module dra_corr #(
	parameter int NIBS = 2
) (
	input  wire logic [4*NIBS-1:0] sum,
	input  wire logic [NIBS-1:0]   nib_carry,
	input  wire logic              decimal,
	output logic      [4*NIBS-1:0] corrected
);
	genvar n;
	generate
		for (n = 0; n < NIBS; n++) begin : g_nib
			// Adding ten in four bits drops the borrow out of the nibble
			assign corrected[4*n +: 4] = (decimal && !nib_carry[n]) ?
				4'(sum[4*n +: 4] + `DRA_DEC_TEN) : sum[4*n +: 4]; // RULE9 RULE10 RULE23 RULE8
		end
	endgenerate
endmodule
`default_nettype wire

// file: bench/dra_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module dra_ctl (
	input  wire logic        clk_sys,
	output logic      [7:0]  a_bus,
	output logic      [7:0]  b_bus,
	output logic             first_source_load_field,
	output logic             second_source_load_field,
	output logic      [2:0]  first_operand_gate_field,
	output logic      [1:0]  second_operand_gate_field,
	output logic      [1:0]  arith_mode_field,
	output logic      [2:0]  carry_function_field,
	output logic             alu_strobe,
	output logic             insert_carry,
	output logic             carry_branch_mnemonic,
	output logic             bit_one_carry_branch,
	output logic      [10:0] rail_fault_inject
);
	initial {a_bus, b_bus, first_source_load_field, second_source_load_field, first_operand_gate_field,
		second_operand_gate_field, arith_mode_field, carry_function_field, alu_strobe, insert_carry,
		carry_branch_mnemonic, bit_one_carry_branch, rail_fault_inject} = 43'h0;
	// One microword walk: load, execute, branch test, idle
	task automatic step(input logic [7:0] a, b, input logic [2:0] fg, input logic [1:0] sg, md,
		input logic [2:0] cc, input logic ins, input logic [10:0] inj);
		@(negedge clk_sys);
		a_bus = a;
		b_bus = b;
		first_source_load_field = 1'b1;
		second_source_load_field = 1'b1;
		@(negedge clk_sys);
		first_source_load_field = 1'b0;
		second_source_load_field = 1'b0;
		// Released buses must not keep their value, or a missed load would go unseen
		a_bus = ~a;
		b_bus = ~b;
		first_operand_gate_field = fg;
		second_operand_gate_field = sg;
		arith_mode_field = md;
		carry_function_field = cc;
		insert_carry = ins;
		rail_fault_inject = inj;
		alu_strobe = 1'b1;
		@(negedge clk_sys);
		alu_strobe = 1'b0;
		insert_carry = 1'b0;
		rail_fault_inject = 11'h0;
		carry_branch_mnemonic = 1'b1;
		bit_one_carry_branch = 1'b1;
		@(negedge clk_sys);
		carry_branch_mnemonic = 1'b0;
		bit_one_carry_branch = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: bench/dual_rail_byte_alu_test.sv
`timescale 1ns/100ps
`default_nettype none
module dual_rail_byte_alu_test;
	logic        clk_sys, reset, check_stop_sw, hard_stop_sw, mc7_clear, addr_latch_set_req, st;
	logic [7:0]  a_bus, b_bus, z_bus_true, z_bus_comp;
	logic [2:0]  first_operand_gate_field, carry_function_field;
	logic [1:0]  second_operand_gate_field, arith_mode_field;
	logic [10:0] rail_fault_inject;
	logic        first_source_load_field, second_source_load_field, alu_strobe, insert_carry;
	logic        carry_branch_mnemonic, bit_one_carry_branch, carry_status_latch, carry_out_zero;
	logic        carry_out_one, recomplement_needed, next_addr_bit6, next_addr_bit7, arith_unit_check;
	logic        addr_latch_set, machine_check_7, any_machine_check, hard_stop, clock_start;
	int          mismatches, checked;
	dra_ctl i_ctl (.*);
	dra_alu i_dut (.*);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [7:0] e, g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Reference: position zero is bit 7; corrector adds ten per uncarried nibble
	task automatic op(input logic [7:0] a, b, input logic [2:0] fg, input logic [1:0] sg, md,
		input logic [2:0] cc, input logic ins);
		logic [8:0] t;
		logic [7:0] ga, gb, s, m;
		logic [4:0] lo;
		logic       cin, c0, c1, lg;
		ga = fg == 3'h0 ? a : fg == 3'h2 ? a & 8'hf0 : fg == 3'h3 ? a & 8'h0f : fg == 3'h4 ? {a[3:0], a[7:4]} : 8'h00;
		gb = sg == 2'h0 ? b : sg == 2'h2 ? b & 8'hf0 : sg == 2'h3 ? b & 8'h0f : 8'h00;
		if (md[0]) gb = ~gb;
		else if (md[1]) gb = {gb[7:4] + 4'h6, gb[3:0] + 4'h6};
		lg = cc == 3'h2 || cc == 3'h3 || cc == 3'h7;
		cin = cc == 3'h1 || cc == 3'h5 || ((cc == 3'h4 || cc == 3'h6) && (ins || st));
		t = ga + gb + cin;
		m = ga[6:0] + gb[6:0] + cin;
		lo = ga[3:0] + gb[3:0] + cin;
		c0 = t[8] & !lg;
		c1 = m[7] & !lg;
		s = cc == 3'h2 ? ga | gb : cc == 3'h3 ? ga & gb : cc == 3'h7 ? ga ^ gb : t[7:0];
		if (md[1] && !lg && !c0) s[7:4] = s[7:4] + 4'ha;
		if (md[1] && !lg && !lo[4]) s[3:0] = s[3:0] + 4'ha;
		if (cc == 3'h4 || cc == 3'h5 || (cc == 3'h6 && cin)) st = c0;
		i_ctl.step(a, b, fg, sg, md, cc, ins, 11'h0);
		#1;
		chk("z_true", s, z_bus_true);
		chk("z_comp", ~s, z_bus_comp);
		chk("carry0", c0, carry_out_zero);
		chk("carry1", c1, carry_out_one);
		chk("status", st, carry_status_latch);
		chk("branch6", c0, next_addr_bit6);
		chk("branch7", c1, next_addr_bit7);
		chk("check", 8'h0, arith_unit_check);
		if (md == 2'h3 && !lg) chk("recomp", !c0, recomplement_needed);
	endtask
	task automatic t_arith;
		op(8'h3c, 8'h5a, 3'h0, 2'h0, 2'h0, 3'h0, 1'b0);
		op(8'hff, 8'h01, 3'h0, 2'h0, 2'h0, 3'h4, 1'b0);
		op(8'h10, 8'h20, 3'h0, 2'h0, 2'h0, 3'h4, 1'b0);
		op(8'h12, 8'h34, 3'h4, 2'h1, 2'h0, 3'h1, 1'b0);
		op(8'hab, 8'hcd, 3'h2, 2'h2, 2'h0, 3'h5, 1'b0);
		op(8'hab, 8'hcd, 3'h3, 2'h3, 2'h1, 3'h6, 1'b0);
		op(8'h80, 8'h7f, 3'h0, 2'h0, 2'h0, 3'h6, 1'b0);
		op(8'h40, 8'h40, 3'h0, 2'h0, 2'h0, 3'h0, 1'b0);
		op(8'h27, 8'h15, 3'h0, 2'h0, 2'h2, 3'h0, 1'b0);
		op(8'h58, 8'h67, 3'h0, 2'h0, 2'h2, 3'h0, 1'b0);
		op(8'h42, 8'h17, 3'h0, 2'h0, 2'h3, 3'h1, 1'b0);
		op(8'h17, 8'h42, 3'h0, 2'h0, 2'h3, 3'h1, 1'b0);
		op(8'hc3, 8'h5a, 3'h5, 2'h0, 2'h0, 3'h2, 1'b0);
		op(8'hc3, 8'h5a, 3'h0, 2'h0, 2'h0, 3'h3, 1'b0);
		op(8'hc3, 8'h5a, 3'h0, 2'h0, 2'h0, 3'h7, 1'b0);
		op(8'h01, 8'h02, 3'h0, 2'h0, 2'h0, 3'h4, 1'b1);
		$display("arith test done");
	endtask
	task automatic t_check;
		for (int i = 0; i < 11; i++) begin
			i_ctl.step(8'h12, 8'h34, 3'h0, 2'h0, 2'h0, 3'h0, 1'b0, 11'h1 << i);
			#1;
			chk("check", 8'h1, arith_unit_check);
			chk("any_check", 8'h1, any_machine_check);
			chk("latch_set", 8'h1, addr_latch_set);
			chk("mc7", 8'h1, machine_check_7);
			chk("hard_stop", 8'h0, hard_stop);
			chk("clk_start", 8'h1, clock_start);
		end
		i_ctl.step(8'h12, 8'h34, 3'h0, 2'h0, 2'h0, 3'h0, 1'b0, 11'h0);
		mc7_clear = 1'b1;
		@(negedge clk_sys);
		mc7_clear = 1'b0;
		check_stop_sw = 1'b1;
		hard_stop_sw = 1'b1;
		chk("mc7", 8'h0, machine_check_7);
		i_ctl.step(8'h12, 8'h34, 3'h0, 2'h0, 2'h0, 3'h0, 1'b0, 11'h008);
		#1;
		chk("latch_set", 8'h0, addr_latch_set);
		chk("clk_start", 8'h0, clock_start);
		chk("hard_stop", 8'h1, hard_stop);
		@(negedge clk_sys);
		reset = 1'b1;
		@(negedge clk_sys);
		chk("clk_start", 8'h1, clock_start);
		chk("z_comp", 8'hff, z_bus_comp);
		reset = 1'b0;
		$display("check test done");
	endtask
	initial begin
		// Address latch request stays up so the check can be seen blocking it
		{reset, check_stop_sw, hard_stop_sw, mc7_clear, addr_latch_set_req, st} = 6'h22;
		reset = 1'b1;
		repeat (16) @(negedge clk_sys);
		chk("z_true", 8'h00, z_bus_true);
		chk("status", 8'h0, carry_status_latch);
		reset = 1'b0;
		t_arith();
		t_check();
		report_and_stop();
	end
	// Whole run is some hundred and forty cycles; this limit leaves ample margin
	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
